/* hw/jts_pkg.sv */
/*
  Constants, register map and carrier types for the jog and travel set
  selection block. Assumes a 32-bit APB3 register bus and a single pclk.
*/
package jts_pkg;
  localparam int unsigned NUM_SETS = 16;
  localparam int unsigned NUM_TERM = 16;
  localparam int unsigned NUM_PINS = NUM_TERM + 5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RAPID = 8'h04;
  localparam logic [7:0] OFS_CREEP = 8'h08;
  localparam logic [7:0] OFS_SLIP = 8'h0c;
  localparam logic [7:0] OFS_SELMAP = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_SELIDX = 8'h18;
  localparam logic [7:0] OFS_ACTIDX = 8'h1c;
  localparam logic [7:0] OFS_TADDR = 8'h20;
  localparam logic [7:0] OFS_TDATA = 8'h24;

  // Control register bit positions
  localparam int unsigned CTRL_POS = 0;
  localparam int unsigned CTRL_JOG = 1;
  localparam int unsigned CTRL_RELEASE = 2;
  localparam int unsigned CTRL_NEXT = 3;
  localparam int unsigned CTRL_FEED = 4;
  localparam int unsigned CTRL_QSTOP = 5;
  localparam int unsigned CTRL_CODE_OUT = 6;
  localparam int unsigned CTRL_W = 7;

  // Selection map: per weight a 5-bit field {assigned, input number}
  localparam int unsigned SELMAP_FLD_W = 5;
  localparam int unsigned SELMAP_EN = 4;

  // Table entry field indices and config word layout
  localparam logic [2:0] FLD_TARGET = 3'h0;
  localparam logic [2:0] FLD_SPEED = 3'h1;
  localparam logic [2:0] FLD_ACCEL = 3'h2;
  localparam logic [2:0] FLD_DECEL = 3'h3;
  localparam logic [2:0] FLD_CFG = 3'h4;
  localparam logic [2:0] FLD_SWPT = 3'h5;
  localparam int unsigned CFG_MODE_POS = 0;
  localparam int unsigned CFG_COND_POS = 4;
  localparam int unsigned CFG_REPS_POS = 8;
  localparam int unsigned CFG_FOLLOW_POS = 16;
  localparam int unsigned TADDR_FLD_POS = 4;

  // Values after reset
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h10;
  localparam logic [31:0] RAPID_RST = 32'h0000_03e8;
  localparam logic [31:0] CREEP_RST = 32'h0000_01f4;
  localparam logic [31:0] SLIP_RST = 32'h0000_0000;
  localparam logic [31:0] SPEED_RST = 32'h0000_03e8;
  localparam logic [31:0] RAMP_RST = 32'h0000_2710;
  localparam logic [4:0] FOLLOW_NONE = 5'h1f;

  typedef enum logic [1:0] {MODE_ABS, MODE_REL, MODE_SPEED, MODE_RSVD} jts_mode_t;
  typedef enum logic [1:0] {COND_SW, COND_DT, COND_SWDT, COND_WSTP} jts_cond_t;
  typedef enum logic [1:0] {JOG_IDLE, JOG_CREEP, JOG_RAPID, JOG_LOCK} jts_jog_t;

  typedef struct packed {
    logic [31:0] target;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] swpt;
    logic [7:0] reps;
    logic [4:0] follow;
    jts_cond_t cond;
    jts_mode_t mode;
  } jts_set_t;

  localparam jts_set_t SET_RST = '{target: 32'h0, speed: SPEED_RST, accel: RAMP_RST, decel: RAMP_RST,
                                   swpt: 32'h0, reps: 8'h00, follow: FOLLOW_NONE, cond: COND_SW,
                                   mode: MODE_REL};

  // Terminal pins as they arrive
  typedef struct packed {
    logic [NUM_TERM-1:0] term;
    logic jog_positive_signal;
    logic jog_negative_signal;
    logic set_release_trigger;
    logic next_start_trigger;
    logic feed_enable;
  } jts_pins_t;

  // Command to the profile generator
  typedef struct packed {
    logic [31:0] target;
    logic [31:0] speed;
    logic [31:0] accel;
    logic [31:0] decel;
    logic [31:0] slip;
    jts_mode_t mode;
    logic dir_positive;
    logic run;
    logic hold;
    logic quick_ramp;
  } jts_cmd_t;
endpackage : jts_pkg

/* hw/jts_top.sv */
/*
  Jog and travel set selection logic with its APB3 register slave.
  Assumes terminal pins asynchronous to pclk, and a profile generator on
  pclk that reports standstill and pulses target reached.
*/
// Behaviour
// [R1] Jog only in positioning control, endless speed
// [R2] Rapid 1000 and creep 500 jog speeds
// [R3] Jog activation only at standstill
// [R4] One jog signal gives creep speed
// [R5] Second signal in creep gives rapid
// [R6] First signal dropped in rapid stops
// [R7] First signal again resumes at creep
// [R8] Two jog inputs, positive and negative
// [R9] Second dropped gives creep, both dropped stop
// [R10] Sixteen travel sets, index 0 to 15
// [R11] Set holds target, mode, speed, ramps, sequencing
// [R12] One slip time for all sets
// [R13] Active set readable and on code outputs
// [R14] Index from four weighted selection inputs
// [R15] Unassigned selection weights read as zero
// [R16] Set starts only on release trigger; next start also starts selected if no repeat or follow-up waits
// [R17] Release aborts motion and follow-up sequence
// [R18] Next start advances, else starts selected
// [R19] Selected index readable, reset zero
// [R20] Active set index readable, reset zero
// [R21] Feed withdrawal holds and later resumes; the code holds table travel only, cmd.hold stays low while jogging
`timescale 1ns/1ns
`default_nettype none
module jts_top
  import jts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire jts_pins_t pins,
  input wire logic drive_enabled,
  input wire logic axis_standstill,
  input wire logic target_reached,
  output jts_cmd_t motion_cmd,
  output logic task_start,
  output logic task_abort,
  output logic [3:0] set_code_out
);

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [31:0] rapid;
    logic [31:0] creep;
    logic [31:0] slip;
    logic [4*SELMAP_FLD_W-1:0] selmap;
    logic [3:0] taddr_set;
    logic [2:0] taddr_fld;
    jts_set_t [NUM_SETS-1:0] sets;
    logic [NUM_PINS-1:0] sync1;
    logic [NUM_PINS-1:0] sync2;
    logic [NUM_PINS-1:0] sync3;
    logic [NUM_PINS-1:0] filt;
    jts_jog_t jog_st;
    logic jog_dir_pos;
    logic jog_mode;
    logic [3:0] sel_idx;
    logic [3:0] act_idx;
    jts_set_t cur;
    logic running;
    logic waiting;
    logic [7:0] reps_left;
    jts_cmd_t cmd;
    logic start_p;
    logic abort_p;
    logic [3:0] code_out;
    logic ready;
    logic [31:0] rdata;
    logic slverr;
  } jts_state_t;

  jts_state_t s;
  jts_state_t n;

  // Next state of the whole block
  always_comb begin
    logic [NUM_PINS-1:0] agree;
    jts_pins_t fp;
    jts_pins_t pp;
    logic first_on;
    logic second_on;
    logic second_rise;
    logic wr;
    logic bus_rel;
    logic bus_next;
    logic rel_ev;
    logic next_ev;
    logic [3:0] start_idx;
    logic do_start;
    logic keep_reps;
    logic [3:0] sel;
    logic [4:0] fmap;
    logic [31:0] rd;
    logic hit;
    jts_set_t ts;
    agree = '0;
    fp = '0;
    pp = '0;
    first_on = 1'b0;
    second_on = 1'b0;
    second_rise = 1'b0;
    wr = 1'b0;
    bus_rel = 1'b0;
    bus_next = 1'b0;
    rel_ev = 1'b0;
    next_ev = 1'b0;
    start_idx = 4'h0;
    do_start = 1'b0;
    keep_reps = 1'b0;
    sel = 4'h0;
    fmap = 5'h00;
    rd = 32'h0;
    hit = 1'b1;
    ts = SET_RST;
    n = s;
    n.start_p = 1'b0;
    n.abort_p = 1'b0;
    n.ready = 1'b0;
    n.slverr = 1'b0;

    // Three-stage synchroniser; a level counts once stages two and three agree
    n.sync1 = pins;
    n.sync2 = s.sync1;
    n.sync3 = s.sync2;
    agree = ~(s.sync2 ^ s.sync3);
    n.filt = (s.filt & ~agree) | (s.sync2 & agree);
    // Filtered levels now and one cycle ago, for edge detection
    fp = jts_pins_t'(n.filt);
    pp = jts_pins_t'(s.filt);

    // Index from the weighted selection inputs
    for (int b = 0; b < 4; b++) begin
      fmap = s.selmap[b*SELMAP_FLD_W +: SELMAP_FLD_W];
      sel[b] = fmap[SELMAP_EN] & fp.term[fmap[3:0]]; // [R14] [R15]
    end
    n.sel_idx = sel; // [R19]

    // APB write strobe, taken at the edge where pready is sampled high
    wr = psel & penable & pwrite & s.ready;
    bus_rel = wr & (paddr == OFS_CTRL) & pwdata[CTRL_RELEASE];
    bus_next = wr & (paddr == OFS_CTRL) & pwdata[CTRL_NEXT];
    if (wr) begin
      unique case (paddr)
        OFS_CTRL: n.ctrl = pwdata[CTRL_W-1:0] & ~(7'h01 << CTRL_RELEASE) & ~(7'h01 << CTRL_NEXT);
        OFS_RAPID: n.rapid = pwdata; // [R2]
        OFS_CREEP: n.creep = pwdata; // [R2]
        OFS_SLIP: n.slip = pwdata; // [R12]
        OFS_SELMAP: n.selmap = pwdata[4*SELMAP_FLD_W-1:0];
        OFS_TADDR: begin
          n.taddr_set = pwdata[3:0];
          n.taddr_fld = pwdata[TADDR_FLD_POS +: 3];
        end
        OFS_TDATA: begin
          // Indirect write into one field of one set
          unique case (s.taddr_fld)
            FLD_TARGET: n.sets[s.taddr_set].target = pwdata; // [R10] [R11]
            FLD_SPEED: n.sets[s.taddr_set].speed = pwdata;
            FLD_ACCEL: n.sets[s.taddr_set].accel = pwdata;
            FLD_DECEL: n.sets[s.taddr_set].decel = pwdata;
            FLD_CFG: begin
              n.sets[s.taddr_set].mode = jts_mode_t'(pwdata[CFG_MODE_POS +: 2]);
              n.sets[s.taddr_set].cond = jts_cond_t'(pwdata[CFG_COND_POS +: 2]);
              n.sets[s.taddr_set].reps = pwdata[CFG_REPS_POS +: 8];
              n.sets[s.taddr_set].follow = pwdata[CFG_FOLLOW_POS +: 5];
            end
            FLD_SWPT: n.sets[s.taddr_set].swpt = pwdata;
            default: ;
          endcase
        end
        default: ;
      endcase
    end

    // Jog mode is entered only from positioning control at standstill
    if (!s.ctrl[CTRL_POS] || !s.ctrl[CTRL_JOG]) begin
      n.jog_mode = 1'b0; // [R1]
      n.jog_st = JOG_IDLE;
    end else if (!s.jog_mode && axis_standstill && !s.running && !s.waiting) begin
      n.jog_mode = 1'b1; // [R3]
    end

    // Jog sequence: first signal carries direction, second selects rapid
    first_on = s.jog_dir_pos ? fp.jog_positive_signal : fp.jog_negative_signal; // [R8]
    second_on = s.jog_dir_pos ? fp.jog_negative_signal : fp.jog_positive_signal;
    second_rise = second_on & ~(s.jog_dir_pos ? pp.jog_negative_signal : pp.jog_positive_signal);
    // State steps only while jog mode stays on
    if (s.jog_mode && n.jog_mode) begin
      unique case (s.jog_st)
        JOG_IDLE: begin
          if (drive_enabled && (fp.jog_positive_signal ^ fp.jog_negative_signal)) begin
            n.jog_st = JOG_CREEP; // [R4]
            n.jog_dir_pos = fp.jog_positive_signal;
          end
        end
        JOG_CREEP: begin
          if (!drive_enabled) begin
            n.jog_st = JOG_IDLE;
          end else if (!first_on) begin
            n.jog_st = second_on ? JOG_LOCK : JOG_IDLE;
          end else if (second_rise) begin
            n.jog_st = JOG_RAPID; // [R5]
          end
        end
        JOG_RAPID: begin
          if (!drive_enabled) begin
            n.jog_st = JOG_IDLE;
          end else if (!first_on) begin
            n.jog_st = second_on ? JOG_LOCK : JOG_IDLE; // [R6] [R9]
          end else if (!second_on) begin
            n.jog_st = JOG_CREEP; // [R9]
          end
        end
        JOG_LOCK: begin
          if (!drive_enabled || !second_on) begin
            n.jog_st = JOG_IDLE;
          end else if (first_on) begin
            n.jog_st = JOG_CREEP; // [R7]
          end
        end
      endcase
    end

    // Table triggers: terminal rising edge or bus bit, ignored while jogging
    rel_ev = ((fp.set_release_trigger & ~pp.set_release_trigger) | bus_rel) & s.ctrl[CTRL_POS]
             & ~s.jog_mode; // [R16]
    next_ev = ((fp.next_start_trigger & ~pp.next_start_trigger) | bus_next) & s.ctrl[CTRL_POS]
              & ~s.jog_mode;

    // Release wins over next start, which wins over target reached
    if (rel_ev) begin
      do_start = 1'b1;
      start_idx = sel;
      n.abort_p = s.running | s.waiting; // [R17]
    end else if (next_ev) begin
      if (s.waiting && s.reps_left != 8'h00) begin
        do_start = 1'b1; // [R18]
        keep_reps = 1'b1;
        start_idx = s.act_idx;
      end else if (s.waiting && !s.cur.follow[4]) begin
        do_start = 1'b1; // [R18]
        start_idx = s.cur.follow[3:0];
      end else begin
        do_start = 1'b1; // [R18]
        start_idx = sel;
        n.abort_p = s.running | s.waiting;
      end
    end else if (target_reached && s.running) begin
      // Set done: wait for next start if a repetition or follow-up remains
      n.running = 1'b0;
      n.waiting = (s.reps_left != 8'h00) | ~s.cur.follow[4];
    end

    // Load the chosen set; a repetition keeps counting down
    if (do_start) begin
      ts = s.sets[start_idx];
      n.cur = ts;
      n.act_idx = start_idx; // [R20]
      n.running = 1'b1;
      n.waiting = 1'b0;
      n.start_p = 1'b1;
      if (keep_reps) begin
        n.reps_left = s.reps_left - 8'h01;
      end else begin
        n.reps_left = (ts.mode == MODE_REL) ? ts.reps : 8'h00;
      end
    end

    // Leaving positioning control drops any table task
    if (!s.ctrl[CTRL_POS]) begin
      n.running = 1'b0;
      n.waiting = 1'b0;
    end

    // Command to the profile generator
    if (n.jog_mode) begin
      n.cmd.target = 32'h0;
      n.cmd.speed = (n.jog_st == JOG_RAPID) ? s.rapid : s.creep; // [R2]
      n.cmd.accel = 32'h0;
      n.cmd.decel = 32'h0;
      n.cmd.mode = MODE_SPEED; // [R1]
      n.cmd.dir_positive = n.jog_dir_pos;
      n.cmd.run = (n.jog_st == JOG_CREEP) | (n.jog_st == JOG_RAPID);
      n.cmd.hold = 1'b0;
    end else begin
      n.cmd.target = n.cur.target;
      n.cmd.speed = n.cur.speed;
      n.cmd.accel = n.cur.accel;
      n.cmd.decel = n.cur.decel;
      n.cmd.mode = n.cur.mode;
      n.cmd.dir_positive = (n.cur.mode == MODE_SPEED) ? ~n.cur.speed[31] : 1'b1;
      n.cmd.run = n.running;
      n.cmd.hold = n.running & ~(fp.feed_enable & n.ctrl[CTRL_FEED]); // [R21]
    end
    // Fields common to jogging and table travel
    n.cmd.slip = s.slip; // [R12]
    n.cmd.quick_ramp = n.ctrl[CTRL_QSTOP]; // [R21]
    n.code_out = n.ctrl[CTRL_CODE_OUT] ? n.act_idx : 4'h0; // [R13]

    // APB read decode and answer one cycle into the access phase
    if (psel && penable && !s.ready) begin
      n.ready = 1'b1;
      unique case (paddr)
        OFS_CTRL: rd = {25'h0, s.ctrl};
        OFS_RAPID: rd = s.rapid;
        OFS_CREEP: rd = s.creep;
        OFS_SLIP: rd = s.slip;
        OFS_SELMAP: rd = {12'h0, s.selmap};
        OFS_STATUS: rd = {16'h0, s.reps_left, s.cmd.hold, s.waiting, s.running, s.jog_mode,
                          s.jog_dir_pos, s.jog_st, axis_standstill};
        OFS_SELIDX: rd = {28'h0, s.sel_idx}; // [R19]
        OFS_ACTIDX: rd = {28'h0, s.act_idx}; // [R13] [R20]
        OFS_TADDR: rd = {25'h0, s.taddr_fld, s.taddr_set};
        OFS_TDATA: begin
          ts = s.sets[s.taddr_set];
          unique case (s.taddr_fld)
            FLD_TARGET: rd = ts.target;
            FLD_SPEED: rd = ts.speed;
            FLD_ACCEL: rd = ts.accel;
            FLD_DECEL: rd = ts.decel;
            FLD_CFG: rd = {11'h0, ts.follow, ts.reps, 2'h0, ts.cond, 2'h0, ts.mode};
            FLD_SWPT: rd = ts.swpt;
            default: hit = 1'b0;
          endcase
        end
        default: hit = 1'b0;
      endcase
      // A write answers with zero data
      n.rdata = pwrite ? 32'h0 : rd;
      n.slverr = ~hit;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.rapid <= RAPID_RST;
      s.creep <= CREEP_RST;
      s.slip <= SLIP_RST;
      s.sets <= {NUM_SETS{SET_RST}};
      s.cur <= SET_RST;
      s.jog_st <= JOG_IDLE;
      s.jog_dir_pos <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;
  assign motion_cmd = s.cmd;
  assign task_start = s.start_p;
  assign task_abort = s.abort_p;
  assign set_code_out = s.code_out;

endmodule : jts_top
`default_nettype wire

/* testbench/jts_checker_asserts.sv */
/* Port checker for jts_top: bus timing, task pulses and index reads.
   Assumes one pclk domain and presetn active low. */
`timescale 1ns/1ns
`default_nettype none
module jts_checker
  import jts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire jts_pins_t pins,
  input wire logic drive_enabled,
  input wire logic axis_standstill,
  input wire logic target_reached,
  input wire jts_cmd_t motion_cmd,
  input wire logic task_start,
  input wire logic task_abort,
  input wire logic [3:0] set_code_out
);
  logic done;
  logic code_en;
  logic map_zero;
  assign done = psel && penable && pready;
  // Shadow of code output enable and of an empty selection map
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_en <= 1'b0;
      map_zero <= 1'b1;
    end else if (done && pwrite && paddr == OFS_CTRL) begin
      code_en <= pwdata[CTRL_CODE_OUT];
    end else if (done && pwrite && paddr == OFS_SELMAP) begin
      map_zero <= (pwdata == 32'h0);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && !penable ##1 psel && penable;
  endsequence
  property p_ready_time;
    s_access |=> pready;
  endproperty
  a_ready_time: assert property (p_ready_time) else $error("pready late");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_err_unmapped;
    done && paddr >= 8'h28 |-> pslverr && prdata == 32'h0;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
  property p_abort_start;
    task_abort |-> task_start;
  endproperty
  a_abort_start: assert property (p_abort_start) else $error("abort without start");
  property p_start_run;
    task_start |-> motion_cmd.run;
  endproperty
  a_start_run: assert property (p_start_run) else $error("start without run");
  property p_code_off;
    (!code_en) [*3] |-> set_code_out == 4'h0;
  endproperty
  a_code_off: assert property (p_code_off) else $error("code out while disabled");
  property p_sel_zero;
    done && !pwrite && paddr == OFS_SELIDX && map_zero |-> prdata == 32'h0;
  endproperty
  a_sel_zero: assert property (p_sel_zero) else $error("unassigned weights not zero");
  property p_idx_width;
    done && !pwrite && (paddr == OFS_SELIDX || paddr == OFS_ACTIDX) |-> prdata[31:4] == 28'h0;
  endproperty
  a_idx_width: assert property (p_idx_width) else $error("index above 15");
endmodule : jts_checker
bind jts_top jts_checker jts_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .drive_enabled(drive_enabled),
  .axis_standstill(axis_standstill), .target_reached(target_reached), .motion_cmd(motion_cmd),
  .task_start(task_start), .task_abort(task_abort), .set_code_out(set_code_out));
`default_nettype wire

/* testbench/jts_axis_model.sv */
/* Profile generator model: travels a table task for a set time, pauses
   while held, reports standstill. Assumes the pclk domain of jts_top. */
`timescale 1ns/1ns
`default_nettype none
module jts_axis_model
  import jts_pkg::*;
#(
  parameter int unsigned MOVE_CYCLES = 60,
  parameter int unsigned STOP_CYCLES = 3
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire jts_cmd_t motion_cmd,
  input wire logic task_start,
  output logic axis_standstill,
  output logic target_reached
);
  int unsigned left;
  int unsigned idle;
  // Travel countdown and stop detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      left <= 0;
      idle <= 0;
      axis_standstill <= 1'b1;
      target_reached <= 1'b0;
    end else begin
      target_reached <= 1'b0;
      if (task_start) begin
        left <= MOVE_CYCLES;
      end else if (left > 1 && !motion_cmd.hold) begin
        left <= left - 1;
      end else if (left == 1) begin
        left <= 0;
        target_reached <= 1'b1;
      end
      idle <= motion_cmd.run ? 0 : idle + 1;
      axis_standstill <= !motion_cmd.run && idle >= STOP_CYCLES;
    end
  end
endmodule : jts_axis_model
`default_nettype wire

/* testbench/testbench.sv */
/* Self-checking bench for jts_top: APB master, terminal pins, jog model.
   Assumes jts_axis_model as profile generator and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module testbench
  import jts_pkg::*;
;
  logic pclk = 0, presetn, psel = 0, penable = 0, pwrite = 0, drive_enabled = 1;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd, rapid, creep, slip, tg0, tg1;
  logic pready, pslverr, task_start, task_abort, axis_standstill, target_reached, er;
  logic [3:0] set_code_out;
  logic [15:0] t;
  jts_pins_t pins = '0;
  jts_cmd_t motion_cmd;
  int bad_count = 0, checks = 0, seed = 16172, starts = 0, aborts = 0, st = 0, first = 1, idx;
  int steps[$] = '{2, 3, 1, 3, 2, 3, 2, 0, 1, 3, 2, 0, 1, 3, 0};
  always #5 pclk = ~pclk;
  // Count task pulses away from the active edge
  always @(negedge pclk) begin
    starts += task_start;
    aborts += task_abort;
  end
  jts_top jts_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .drive_enabled(drive_enabled),
    .axis_standstill(axis_standstill), .target_reached(target_reached),
    .motion_cmd(motion_cmd), .task_start(task_start), .task_abort(task_abort),
    .set_code_out(set_code_out));
  jts_axis_model jts_axis_model_inst (.pclk(pclk), .presetn(presetn), .motion_cmd(motion_cmd),
    .task_start(task_start), .axis_standstill(axis_standstill), .target_reached(target_reached));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++k < 50);
    if (k >= 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rdchk
  // Wait, bounded, for the running table task to end
  task automatic wait_end;
    int k;
    k = 0;
    while (motion_cmd.run !== 1'b0 && k < 200) begin
      @(posedge pclk);
      k++;
    end
    chk("run end", motion_cmd.run, 1'b0);
  endtask : wait_end
  // Drive jog pins, step the reference model, compare the command
  task automatic jog(input int p, input int q, input logic en);
    int f, s;
    f = first ? p : q;
    s = first ? q : p;
    @(posedge pclk);
    pins.jog_positive_signal <= p[0];
    pins.jog_negative_signal <= q[0];
    drive_enabled <= en;
    if (!en) begin
      st = 0;
    end else if (st == 0 && (p ^ q)) begin
      st = 1;
      first = p;
    end else if (st == 1) st = !f ? 0 : (s ? 2 : 1);
    else if (st == 2) st = !f ? (s ? 3 : 0) : (s ? 2 : 1);
    else if (st == 3) st = f ? 1 : (s ? 3 : 0);
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    chk("jog run", motion_cmd.run, st == 1 || st == 2);
    if (st == 1 || st == 2) begin
      chk("jog speed", motion_cmd.speed, st == 2 ? rapid : creep);
      chk("jog dir", motion_cmd.dir_positive, first);
      chk("jog mode", motion_cmd.mode, MODE_SPEED);
    end
  endtask : jog
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
  initial begin
    presetn <= 1'b0;
    pins.feed_enable <= 1'b1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_CTRL, 32'h10, "ctrl");
    rdchk(OFS_RAPID, 32'd1000, "rapid");
    rdchk(OFS_CREEP, 32'd500, "creep");
    rdchk(OFS_SELIDX, 32'h0, "selidx");
    rdchk(OFS_ACTIDX, 32'h0, "actidx");
    apb(1'b1, 8'h40, 32'h1);
    chk("unmapped", er, 1'b1);
    rapid = $random(seed);
    creep = $random(seed);
    slip = $random(seed);
    apb(1'b1, OFS_RAPID, rapid);
    apb(1'b1, OFS_CREEP, creep);
    apb(1'b1, OFS_SLIP, slip);
    rdchk(OFS_CREEP, creep, "creep");
    // Axis idle since reset, so jog may start
    apb(1'b1, OFS_CTRL, 32'h13);
    foreach (steps[i]) jog(steps[i] / 2, steps[i] % 2, 1'b1);
    // No jog motion while the drive is not enabled
    jog(1, 0, 1'b0);
    jog(0, 0, 1'b0);
    jog(0, 1, 1'b1);
    jog(0, 0, 1'b1);
    // Weight 0 from terminal 3, weight 3 from terminal 0
    apb(1'b1, OFS_CTRL, 32'h51);
    apb(1'b1, OFS_SELMAP, 32'h13 | (32'h10 << 15));
    repeat (3) begin
      t = 16'($random(seed));
      @(posedge pclk);
      pins.term <= t;
      repeat (6) @(posedge pclk);
      idx = t[3] + 8 * t[0];
      rdchk(OFS_SELIDX, idx, "selidx");
    end
    apb(1'b1, OFS_CTRL, 32'h55);
    @(posedge pclk);
    pins.set_release_trigger <= 1'b1;
    repeat (8) @(posedge pclk);
    pins.set_release_trigger <= 1'b0;
    chk("starts", starts, 2);
    chk("aborts", aborts, 1);
    rdchk(OFS_ACTIDX, idx, "actidx");
    chk("code", set_code_out, idx);
    @(posedge pclk);
    pins.feed_enable <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("hold", motion_cmd.hold, 1'b1);
    pins.feed_enable <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("resume", {motion_cmd.hold, motion_cmd.run}, 2'b01);
    wait_end();
    @(posedge pclk);
    pins.next_start_trigger <= 1'b1;
    repeat (8) @(posedge pclk);
    pins.next_start_trigger <= 1'b0;
    chk("next", starts * 2 + aborts, 32'd7);
    // Set 1 repeats once, then hands over to set 8
    tg0 = $random(seed);
    tg1 = $random(seed);
    apb(1'b1, OFS_TADDR, 32'h01);
    apb(1'b1, OFS_TDATA, tg0);
    apb(1'b1, OFS_TADDR, 32'h08);
    apb(1'b1, OFS_TDATA, tg1);
    apb(1'b1, OFS_TADDR, 32'h41);
    apb(1'b1, OFS_TDATA, 32'h0008_0101);
    rdchk(OFS_TDATA, 32'h0008_0101, "cfg");
    wait_end();
    @(posedge pclk);
    pins.term <= 16'h0008;
    repeat (6) @(posedge pclk);
    apb(1'b1, OFS_CTRL, 32'h55);
    @(posedge pclk);
    chk("set target", motion_cmd.target, tg0);
    chk("slip", motion_cmd.slip, slip);
    chk("accel", motion_cmd.accel, 32'd10000);
    wait_end();
    apb(1'b1, OFS_CTRL, 32'h59);
    @(posedge pclk);
    chk("repeat", motion_cmd.target, tg0);
    rdchk(OFS_ACTIDX, 32'h1, "actidx");
    wait_end();
    apb(1'b1, OFS_CTRL, 32'h59);
    @(posedge pclk);
    chk("follow", motion_cmd.target, tg1);
    rdchk(OFS_ACTIDX, 32'h8, "actidx");
    chk("code", set_code_out, 4'h8);
    // Jog request while a task runs must not enter jog mode
    apb(1'b1, OFS_CTRL, 32'h53);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("jog refused", rd[4], 1'b0);
    chk("starts all", starts, 6);
    chk("aborts all", aborts, 1);
    complete_run();
  end
endmodule : testbench
`default_nettype wire
